/* File: hdl/i2crp_pkg.sv */
// Purpose: constants and types of the two-wire register port
// Assumes: used by the sysport and top files of the port
// Notes:   strap codes 0..3 mean supply, ground, clock line, data line
package i2crp_pkg;

  // ==========================================================
  // address and subaddress layout
  localparam logic [7:0] ADDR_BASE     = 8'h90;
  localparam int         ADDR_HI_SHIFT = 3;
  localparam int         ADDR_LO_SHIFT = 1;
  localparam int         SUB_SEL_MSB   = 6;
  localparam int         SUB_SEL_LSB   = 3;
  localparam int         SUB_CH_MSB    = 2;
  localparam int         SUB_CH_LSB    = 1;
  localparam int         DIR_BIT       = 0;
  localparam logic [2:0] BIT_LAST      = 3'h7;
  localparam logic [2:0] BIT_FIRST     = 3'h0;
  localparam logic [7:0] IDLE_BYTE     = 8'hFF;

  // ==========================================================
  // types
  typedef enum logic [2:0] {
    ST_IDLE, ST_RX, ST_ACK_WAIT, ST_ACK, ST_TX, ST_TX_ACK, ST_IGNORE
  } i2crp_state_type;

  typedef enum logic [1:0] {PH_ADDR, PH_SUB, PH_WDATA} i2crp_phase_type;

  typedef struct packed {
    logic       is_rd;
    logic [3:0] sel;
    logic [1:0] chan;
    logic [7:0] data;
  } i2crp_req_type;

  // ==========================================================
  // own address byte from the two strap codes
  function automatic logic [7:0] i2crp_own_addr(input logic [1:0] hi, input logic [1:0] lo);
    i2crp_own_addr = ADDR_BASE + (8'(hi) << ADDR_HI_SHIFT) + (8'(lo) << ADDR_LO_SHIFT);
  endfunction

endpackage

/* File: hdl/i2crp_sync.sv */
// Purpose: two flip-flop synchroniser for levels
// Assumes: input is a level or a word held stable long enough
// Notes:   only the second stage is visible outside
module i2crp_sync #(
  parameter int               WIDTH   = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input  wire logic             clk,
  input  wire logic             rst_b,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_q;

  // ==========================================================
  // stages
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_q <= RST_VAL;
      q      <= RST_VAL;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end

endmodule

/* File: hdl/i2crp_sysport.sv */
// Purpose: system-clock end of the register request handshake
// Assumes: request word is held stable while its toggle is pending
// Notes:   read data must be valid one cycle after the read strobe
module i2crp_sysport
  import i2crp_pkg::*;
(
  input  wire logic          sys_clk,
  input  wire logic          rst_b,
  input  wire logic          req_tgl,
  input  wire i2crp_req_type req,
  input  wire logic [7:0]    rd_data_in,
  output logic               ack_tgl_q,
  output logic [7:0]         rd_data_q,
  output logic               wr_stb_q,
  output logic               rd_stb_q,
  output logic [3:0]         sel_q,
  output logic [1:0]         chan_q,
  output logic [7:0]         wr_data_q
);

  logic req_s;
  logic req_p_q;
  logic rd_wait_q;
  logic new_req;

  i2crp_sync #(.WIDTH(1), .RST_VAL(1'b0)) u_req_sync (
    .clk   (sys_clk),
    .rst_b (rst_b),
    .d     (req_tgl),
    .q     (req_s)
  );

  assign new_req = req_s ^ req_p_q;

  // ==========================================================
  // strobes and captured fields
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      req_p_q   <= 1'b0;
      wr_stb_q  <= 1'b0;
      rd_stb_q  <= 1'b0;
      rd_wait_q <= 1'b0;
      sel_q     <= '0;
      chan_q    <= '0;
      wr_data_q <= '0;
    end else begin
      req_p_q   <= req_s;
      wr_stb_q  <= new_req & ~req.is_rd;
      rd_stb_q  <= new_req & req.is_rd;
      rd_wait_q <= rd_stb_q;
      if (new_req) begin
        sel_q     <= req.sel;
        chan_q    <= req.chan;
        wr_data_q <= req.data;
      end
    end
  end

  // ==========================================================
  // answer; data held until the next read so the link can sample it
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ack_tgl_q <= 1'b0;
      rd_data_q <= IDLE_BYTE;
    end else begin
      if (rd_wait_q) begin
        rd_data_q <= rd_data_in;
      end
      if ((new_req && !req.is_rd) || rd_wait_q) begin
        ack_tgl_q <= ~ack_tgl_q;
      end
    end
  end

endmodule

/* File: hdl/i2crp_top.sv */
// Purpose: slave-only two-wire register port of a serial bridge
// Assumes: link_clk free running, well above the bus bit rate
// Notes:   no clock stretching; register file lives outside on sys_clk
//
// How it works
// - data falling while clock high is start
// - data rising while clock high is stop
// - data stable in clock high phase
// - eight bits, msb first, then acknowledge slot
// - receiver pulls low, transmitter releases in slot
// - acknowledge address, subaddress and write data
// - refuse unacceptable data byte with negative acknowledge
// - bus busy from start until stop
// - first byte: seven-bit address plus direction bit
// - matching address acknowledged, direction picks role
// - address from two straps, base plus offsets
// - subaddress bits 6:3 select, 2:1 channel
// - write data bytes stored at subaddress location
// - read via repeated start, shift until nack
// - repeated start re-evaluates address and direction
module i2crp_top
  import i2crp_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       rst_b,
  input  wire logic       link_clk,
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe,
  input  wire logic [1:0] addr_strap_high_pin,
  input  wire logic [1:0] addr_strap_low_pin,
  input  wire logic [7:0] reg_rd_data,
  output logic            reg_wr_stb,
  output logic            reg_rd_stb,
  output logic [3:0]      reg_sel,
  output logic [1:0]      channel_select_bits,
  output logic [7:0]      reg_wr_data,
  output logic            bus_busy
);

  // ==========================================================
  // link domain signals
  logic [1:0]      pin_s;
  logic            scl_s;
  logic            sda_s;
  logic            scl_p_q;
  logic            sda_p_q;
  logic [3:0]      strap_s;
  logic [7:0]      own_addr_q;
  logic            ack_tgl;
  logic            ack_tgl_s;
  logic [7:0]      rd_data_x;
  i2crp_state_type st_q;
  i2crp_phase_type ph_q;
  logic [2:0]      cnt_q;
  logic [7:0]      shift_q;
  logic            ack_q;
  logic            dir_rd_q;
  logic [3:0]      sel_q;
  logic [1:0]      chan_q;
  logic            busy_q;
  logic            oe_q;
  logic            req_tgl_q;
  i2crp_req_type   req_q;

  logic            start_ev;
  logic            stop_ev;
  logic            scl_rise;
  logic            scl_fall;
  logic [7:0]      rx_byte;
  logic            byte_done;
  logic            addr_match;
  logic            hs_idle;
  logic            issue_rd;
  logic            issue_wr;
  logic            ack_d;

  // ==========================================================
  // pin, strap and acknowledge synchronisers
  i2crp_sync #(.WIDTH(2), .RST_VAL(2'h3)) u_pin_sync (
    .clk   (link_clk),
    .rst_b (rst_b),
    .d     ({scl_in, sda_in}),
    .q     (pin_s)
  );

  assign scl_s = pin_s[1];
  assign sda_s = pin_s[0];

  i2crp_sync #(.WIDTH(4), .RST_VAL(4'h0)) u_strap_sync (
    .clk   (link_clk),
    .rst_b (rst_b),
    .d     ({addr_strap_high_pin, addr_strap_low_pin}),
    .q     (strap_s)
  );

  i2crp_sync #(.WIDTH(1), .RST_VAL(1'b0)) u_ack_sync (
    .clk   (link_clk),
    .rst_b (rst_b),
    .d     (ack_tgl),
    .q     (ack_tgl_s)
  );

  // straps are static; tracking them keeps reset free of port values
  always_ff @(posedge link_clk or negedge rst_b) begin
    if (!rst_b) begin
      own_addr_q <= ADDR_BASE;
    end else begin
      own_addr_q <= i2crp_own_addr(strap_s[3:2], strap_s[1:0]);
    end
  end

  // ==========================================================
  // line events
  always_ff @(posedge link_clk or negedge rst_b) begin
    if (!rst_b) begin
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      scl_p_q <= scl_s;
      sda_p_q <= sda_s;
    end
  end

  // a data edge with the clock high both samples is control, not data
  assign start_ev = scl_s & scl_p_q & sda_p_q & ~sda_s;
  assign stop_ev  = scl_s & scl_p_q & ~sda_p_q & sda_s;
  assign scl_rise = scl_s & ~scl_p_q;
  assign scl_fall = ~scl_s & scl_p_q;

  // ==========================================================
  // byte decisions
  assign rx_byte    = {shift_q[6:0], sda_s};
  assign byte_done  = (st_q == ST_RX) && scl_rise && (cnt_q == BIT_LAST);
  assign addr_match = rx_byte[7:1] == own_addr_q[7:1];
  assign hs_idle    = req_tgl_q == ack_tgl_s;

  assign issue_rd = hs_idle && ((byte_done && ph_q == PH_ADDR && addr_match && rx_byte[DIR_BIT]) ||
                                (st_q == ST_TX_ACK && scl_rise && !sda_s));
  assign issue_wr = hs_idle && byte_done && ph_q == PH_WDATA;

  always_comb begin
    unique case (ph_q)
      PH_ADDR:  ack_d = addr_match;
      PH_SUB:   ack_d = 1'b1;
      PH_WDATA: ack_d = hs_idle;
      default:  ack_d = 1'b0;
    endcase
  end

  // ==========================================================
  // busy flag
  always_ff @(posedge link_clk or negedge rst_b) begin
    if (!rst_b) begin
      busy_q <= 1'b0;
    end else if (start_ev) begin
      busy_q <= 1'b1;
    end else if (stop_ev) begin
      busy_q <= 1'b0;
    end
  end

  // ==========================================================
  // protocol state machine
  always_ff @(posedge link_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_q     <= ST_IDLE;
      ph_q     <= PH_ADDR;
      cnt_q    <= BIT_FIRST;
      shift_q  <= '0;
      ack_q    <= 1'b0;
      dir_rd_q <= 1'b0;
      sel_q    <= '0;
      chan_q   <= '0;
    end else if (start_ev) begin
      // repeated start lands here too, from any state
      st_q  <= ST_RX;
      ph_q  <= PH_ADDR;
      cnt_q <= BIT_FIRST;
    end else if (stop_ev) begin
      st_q <= ST_IDLE;
    end else begin
      unique case (st_q)
        ST_IDLE, ST_IGNORE: begin
          st_q <= st_q;
        end
        ST_RX: begin
          if (scl_rise) begin
            shift_q <= rx_byte;
            cnt_q   <= cnt_q + 3'h1;
          end
          if (byte_done) begin
            ack_q <= ack_d;
            st_q  <= ST_ACK_WAIT;
            if (ph_q == PH_ADDR) begin
              dir_rd_q <= rx_byte[DIR_BIT];
            end
            if (ph_q == PH_SUB) begin
              sel_q  <= rx_byte[SUB_SEL_MSB:SUB_SEL_LSB];
              chan_q <= rx_byte[SUB_CH_MSB:SUB_CH_LSB];
            end
          end
        end
        ST_ACK_WAIT: begin
          if (scl_fall) begin
            st_q <= ST_ACK;
          end
        end
        ST_ACK: begin
          if (scl_fall) begin
            cnt_q <= BIT_FIRST;
            if (!ack_q) begin
              st_q <= ST_IGNORE;
            end else if (ph_q == PH_ADDR && dir_rd_q) begin
              st_q    <= ST_TX;
              shift_q <= rd_data_x;
            end else begin
              st_q <= ST_RX;
              ph_q <= (ph_q == PH_ADDR) ? PH_SUB : PH_WDATA;
            end
          end
        end
        ST_TX: begin
          if (scl_rise) begin
            cnt_q <= cnt_q + 3'h1;
          end
          if (scl_fall) begin
            if (cnt_q == BIT_FIRST) begin
              st_q <= ST_TX_ACK;
            end else begin
              shift_q <= {shift_q[6:0], 1'b0};
            end
          end
        end
        ST_TX_ACK: begin
          if (scl_rise) begin
            ack_q <= ~sda_s;
          end
          if (scl_fall) begin
            cnt_q <= BIT_FIRST;
            if (ack_q) begin
              st_q    <= ST_TX;
              shift_q <= rd_data_x;
            end else begin
              st_q <= ST_IGNORE;
            end
          end
        end
        default: begin
          st_q <= ST_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // data line enable; only ever pulls low, the pull-up makes the high
  always_ff @(posedge link_clk or negedge rst_b) begin
    if (!rst_b) begin
      oe_q <= 1'b0;
    end else if (start_ev || stop_ev) begin
      oe_q <= 1'b0;
    end else if (scl_fall) begin
      unique case (st_q)
        ST_ACK_WAIT: oe_q <= ack_q;
        ST_ACK:      oe_q <= ack_q && ph_q == PH_ADDR && dir_rd_q && !rd_data_x[7];
        ST_TX:       oe_q <= (cnt_q != BIT_FIRST) && !shift_q[6];
        ST_TX_ACK:   oe_q <= ack_q && !rd_data_x[7];
        default:     oe_q <= 1'b0;
      endcase
    end
  end

  always_ff @(posedge link_clk or negedge rst_b) begin
    if (!rst_b) begin
      sda_oe  <= 1'b0;
      sda_out <= 1'b0;
    end else begin
      sda_oe  <= oe_q;
      sda_out <= 1'b0;
    end
  end

  // ==========================================================
  // request toward the system clock; word held while toggle pends
  always_ff @(posedge link_clk or negedge rst_b) begin
    if (!rst_b) begin
      req_tgl_q <= 1'b0;
      req_q     <= '0;
    end else if (issue_rd || issue_wr) begin
      req_tgl_q  <= ~req_tgl_q;
      req_q.is_rd <= issue_rd;
      req_q.sel   <= issue_wr ? sel_q : ((ph_q == PH_SUB) ? rx_byte[SUB_SEL_MSB:SUB_SEL_LSB] : sel_q);
      req_q.chan  <= chan_q;
      req_q.data  <= rx_byte;
    end
  end

  // ==========================================================
  // system clock side
  i2crp_sysport u_sysport (
    .sys_clk    (sys_clk),
    .rst_b      (rst_b),
    .req_tgl    (req_tgl_q),
    .req        (req_q),
    .rd_data_in (reg_rd_data),
    .ack_tgl_q  (ack_tgl),
    .rd_data_q  (rd_data_x),
    .wr_stb_q   (reg_wr_stb),
    .rd_stb_q   (reg_rd_stb),
    .sel_q      (reg_sel),
    .chan_q     (channel_select_bits),
    .wr_data_q  (reg_wr_data)
  );

  // busy flag crosses as a level
  logic busy_s;
  i2crp_sync #(.WIDTH(1), .RST_VAL(1'b0)) u_busy_sync (
    .clk   (sys_clk),
    .rst_b (rst_b),
    .d     (busy_q),
    .q     (busy_s)
  );

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      bus_busy <= 1'b0;
    end else begin
      bus_busy <= busy_s;
    end
  end

endmodule

/* File: sim/i2crp_top_assertions.sv */
// Purpose: port-level checks of the two-wire register port
// Assumes: bus pins seen as wired levels
// Notes:   bound from the bench top
module i2crp_checker (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic link_clk,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic reg_wr_stb,
  input wire logic reg_rd_stb,
  input wire logic bus_busy
);
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================
  // bus conditions
  sequence start_seq;
    scl_in && $past(scl_in) && $fell(sda_in);
  endsequence

  sequence stop_seq;
    scl_in && $past(scl_in) && $rose(sda_in);
  endsequence

  // ==========================================================
  // checks
  chk_start_sets_busy: assert property (@(posedge sys_clk) disable iff (!rst_b)
    start_seq |-> ##[1:40] bus_busy) else $error("busy not raised after start");
  chk_stop_clears_busy: assert property (@(posedge sys_clk) disable iff (!rst_b)
    stop_seq |-> ##[1:40] !bus_busy) else $error("busy not cleared after stop");
  chk_never_high: assert property (@(posedge sys_clk) disable iff (!rst_b)
    sda_out == 1'b0) else $error("data line driven high");
  chk_oe_clock_low: assert property (@(posedge link_clk) disable iff (!rst_b)
    $changed(sda_oe) |-> !scl_in && !$past(scl_in)) else $error("data changed in clock high");
  chk_oe_when_busy: assert property (@(posedge sys_clk) disable iff (!rst_b)
    sda_oe |-> bus_busy) else $error("data pulled on idle bus");
  chk_wr_one_cycle: assert property (@(posedge sys_clk) disable iff (!rst_b)
    reg_wr_stb |=> !reg_wr_stb) else $error("write strobe too long");
  chk_rd_one_cycle: assert property (@(posedge sys_clk) disable iff (!rst_b)
    reg_rd_stb |=> !reg_rd_stb) else $error("read strobe too long");
  chk_strobe_busy: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (reg_wr_stb || reg_rd_stb) |-> bus_busy) else $error("strobe outside a transfer");
endmodule

/* File: sim/i2crp_master.sv */
// Purpose: behavioural bus master for the register port
// Assumes: open-drain data, clock only moves inside frames
// Notes:   data changes mid low phase, clear of the sync lag
module i2crp_master #(
  parameter int HALF_NS = 1250
) (
  output logic     scl,
  output logic     sda_low,
  input wire logic sda
);
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================
  // frame tasks
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  task automatic start();
    #(HALF_NS/2) sda_low = 1'b0;
    #(HALF_NS/2) scl = 1'b1;
    #(HALF_NS) sda_low = 1'b1;
    #(HALF_NS) scl = 1'b0;
  endtask

  task automatic stop();
    #(HALF_NS/2) sda_low = 1'b1;
    #(HALF_NS/2) scl = 1'b1;
    #(HALF_NS) sda_low = 1'b0;
    #(HALF_NS);
  endtask

  task automatic clk_bit(input logic drive_low, output logic seen);
    #(HALF_NS/2) sda_low = drive_low;
    #(HALF_NS/2) scl = 1'b1;
    #(HALF_NS/2) seen = sda;
    #(HALF_NS/2) scl = 1'b0;
  endtask

  task automatic wbyte(input logic [7:0] b, output logic acked);
    logic s;
    for (int i = 7; i >= 0; i--) clk_bit(!b[i], s);
    clk_bit(1'b0, s);
    acked = !s;
  endtask

  task automatic rbyte(input logic ack, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(1'b0, s);
      b[i] = s;
    end
    clk_bit(ack, s);
  endtask
endmodule

/* File: sim/i2crp_top_test.sv */
// Purpose: self-checking bench of the register port
// Assumes: register file modelled here on sys_clk
// Notes:   read data answers one cycle after the strobe
module i2crp_top_test;
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================
  // signals and clocks
  logic       sys_clk, link_clk, rst_b, sda_oe, sda_out, m_scl, m_sda_low;
  logic       reg_wr_stb, reg_rd_stb, bus_busy;
  logic [1:0] strap_hi, strap_lo, chan;
  logic [3:0] sel;
  logic [7:0] rd_data, wr_data, first_wr;
  int         errors = 0;
  int         comparisons = 0;
  int         wr_cnt = 0;
  // pull-up: line low if either party pulls
  wire logic  sda_line = !(m_sda_low || sda_oe);

  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  initial begin
    link_clk = 1'b0;
    #7;
    forever #40 link_clk = ~link_clk;
  end

  always @(posedge sys_clk) begin
    if (reg_rd_stb) rd_data <= {4'hA, sel};
    if (reg_wr_stb) begin
      if (wr_cnt == 0) first_wr <= wr_data;
      wr_cnt <= wr_cnt + 1;
    end
  end

  i2crp_master m (.scl(m_scl), .sda_low(m_sda_low), .sda(sda_line));

  i2crp_top DUT (
    .sys_clk(sys_clk), .rst_b(rst_b), .link_clk(link_clk), .scl_in(m_scl), .sda_in(sda_line),
    .sda_out(sda_out), .sda_oe(sda_oe), .addr_strap_high_pin(strap_hi), .addr_strap_low_pin(strap_lo),
    .reg_rd_data(rd_data), .reg_wr_stb(reg_wr_stb), .reg_rd_stb(reg_rd_stb), .reg_sel(sel),
    .channel_select_bits(chan), .reg_wr_data(wr_data), .bus_busy(bus_busy)
  );

  // ==========================================================
  // helpers
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic test_done();
    if (errors == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // straps only move on an idle bus, then settle
  task automatic set_straps(input logic [1:0] hi, input logic [1:0] lo);
    @(posedge sys_clk);
    #1;
    strap_hi = hi;
    strap_lo = lo;
    repeat (20) @(posedge sys_clk);
  endtask

  function automatic logic [7:0] own(input int hi, input int lo);
    return 8'h90 + 8'(8 * hi + 2 * lo);
  endfunction

  // ==========================================================
  // scenarios
  task automatic s_write();
    logic a;
    set_straps(2'h0, 2'h0);
    m.start();
    m.wbyte(8'h90, a);
    check(8'(a), 8'h01);
    check(8'(bus_busy), 8'h01);
    m.wbyte(8'hA9, a);
    check(8'(a), 8'h01);
    m.wbyte(8'h3C, a);
    check(8'(a), 8'h01);
    m.wbyte(8'hC3, a);
    check(8'(a), 8'h01);
    m.stop();
    #1us;
    check(8'(wr_cnt), 8'h02);
    check(first_wr, 8'h3C);
    check(wr_data, 8'hC3);
    check(8'(sel), 8'h05);
    check(8'(chan), 8'h00);
    check(8'(bus_busy), 8'h00);
  endtask

  task automatic s_nomatch();
    logic a;
    set_straps(2'h1, 2'h3);
    m.start();
    m.wbyte(8'h9C, a);
    check(8'(a), 8'h00);
    m.wbyte(8'h9E, a);
    check(8'(a), 8'h00);
    m.wbyte(8'h55, a);
    check(8'(a), 8'h00);
    m.stop();
    check(8'(wr_cnt), 8'h02);
  endtask

  task automatic s_map();
    logic a;
    for (int h = 0; h < 4; h++) for (int l = 0; l < 4; l++) begin
      set_straps(2'(h), 2'(l));
      m.start();
      m.wbyte(own(h, l) ^ 8'h40, a);
      check(8'(a), 8'h00);
      m.start();
      m.wbyte(own(h, l), a);
      check(8'(a), 8'h01);
      m.stop();
    end
  endtask

  task automatic s_read();
    logic       a;
    logic [7:0] d;
    set_straps(2'h3, 2'h2);
    m.start();
    m.wbyte(8'hAC, a);
    check(8'(a), 8'h01);
    m.wbyte(8'h48, a);
    check(8'(a), 8'h01);
    m.start();
    m.wbyte(8'hAD, a);
    check(8'(a), 8'h01);
    m.rbyte(1'b1, d);
    check(d, 8'hA9);
    m.rbyte(1'b0, d);
    check(d, 8'hA9);
    m.stop();
    check(8'(sel), 8'h09);
    check(8'(wr_cnt), 8'h02);
  endtask

  // ==========================================================
  // main sequence
  initial begin
    rst_b = 1'b0;
    strap_hi = 2'h0;
    strap_lo = 2'h0;
    repeat (6) @(posedge sys_clk);
    #1 rst_b = 1'b1;
    repeat (10) @(posedge link_clk);
    s_write();
    s_nomatch();
    s_map();
    s_read();
    test_done();
  end
endmodule

bind i2crp_top i2crp_checker chk (
  .sys_clk(sys_clk), .rst_b(rst_b), .link_clk(link_clk), .scl_in(scl_in), .sda_in(sda_in),
  .sda_out(sda_out), .sda_oe(sda_oe), .reg_wr_stb(reg_wr_stb), .reg_rd_stb(reg_rd_stb), .bus_busy(bus_busy)
);
